// ==== src/channel_alarm_defs.vh ====
// Register offsets, field positions and reset values of the channel alarm block
`ifndef CHANNEL_ALARM_DEFS_VH
`define CHANNEL_ALARM_DEFS_VH

// Printed offsets are register indexes; byte address is four times the index
`define IDX_CH_IRQ_EN        8'h04
`define IDX_CH_ALARM_STATE   8'h05
`define IDX_CH_ALARM_CHANGE  8'h06
`define IDX_CH_STRIDE        8'h10
`define IDX_GLOBAL_IRQ       8'h80
`define IDX_GLOBAL_CFG       8'h81
`define IDX_CH_ALARM_LAST    8'h75

`define BIT_TEST_PATTERN     0
`define BIT_SIGNAL_LOSS      1
`define BIT_ALL_ONES         2
`define BIT_VIOLATION        4
`define BIT_FIFO_LIMIT       5
`define BIT_DRIVER_FAIL      6
`define BIT_GLOBAL_IRQ_EN    0
`define BIT_OVERFLOW_MODE    7

`define ALARM_USED_MASK      8'h77
`define ALARM_RESET          8'h00
`define FIFO_NEAR_DISTANCE   3

`endif

// ==== src/fifo_near_limit_check.v ====
// Jitter FIFO pointer distance check for one channel
`timescale 1ns/1ps
`include "channel_alarm_defs.vh"
module fifo_near_limit_check #(
    parameter PTR_W = 6
) (
    input  wire [PTR_W-1:0] rd_ptr_in,
    input  wire [PTR_W-1:0] wr_ptr_in,
    output wire             near_limit_out
);
    wire [PTR_W-1:0] fwd;
    wire [PTR_W-1:0] bwd;
    assign fwd = wr_ptr_in - rd_ptr_in;
    assign bwd = rd_ptr_in - wr_ptr_in;
    // Modular distance within plus or minus three
    assign near_limit_out = (fwd <= `FIFO_NEAR_DISTANCE) || (bwd <= `FIFO_NEAR_DISTANCE);
endmodule

// ==== src/alarm_condition_sync.v ====
// Two-stage synchroniser for a bundle of alarm levels
`timescale 1ns/1ps
module alarm_condition_sync #(
    parameter W = 8
) (
    input  wire         sys_clk_in,
    input  wire         rst_n_in,
    input  wire         clk_en_in,
    input  wire [W-1:0] level_in,
    output wire [W-1:0] level_out
);
    reg [W-1:0] stage1_reg;
    reg [W-1:0] stage2_reg;
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            stage1_reg <= {W{1'b0}};
            stage2_reg <= {W{1'b0}};
        end else if (clk_en_in) begin
            stage1_reg <= level_in;
            stage2_reg <= stage1_reg;
        end
    end
    assign level_out = stage2_reg;
endmodule

// ==== src/channel_alarm_status.v ====
// Per-channel alarm status, change flags and interrupt logic over APB
//
// Functional notes
// - Bit 6 tracks transmit driver failure
// - Status tracks condition regardless of enables
// - Bit 5 set when pointers within three
// - Bit 4 defaults to line code violations
// - Config bit 7 selects counter overflow
// - Violation mode: code, bipolar, excess zeros
// - Bit 2 tracks all-ones detection
// - Bit 1 tracks receive signal loss
// - Bit 0 tracks test pattern detection
// - Status read-only, zero reset, 7,3 unused
// - Eight copies at 0x05 plus sixteen each
// - Status change sets flag, cleared on read
// - Enable register masks per status bit
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "channel_alarm_defs.vh"
module channel_alarm_status #(
    parameter CHANNELS = 8,
    parameter PTR_W    = 6
) (
    input  wire                      sys_clk_in,
    input  wire                      rst_n_in,
    input  wire                      clk_en_in,
    input  wire                      psel_in,
    input  wire                      penable_in,
    input  wire                      pwrite_in,
    input  wire [11:0]               paddr_in,
    input  wire [31:0]               pwdata_in,
    input  wire [3:0]                pstrb_in,
    output wire                      pready_out,
    output reg  [31:0]               prdata_out,
    output wire                      pslverr_out,
    input  wire [CHANNELS-1:0]       driver_fail_in,
    input  wire [CHANNELS*PTR_W-1:0] fifo_rd_ptr_in,
    input  wire [CHANNELS*PTR_W-1:0] fifo_wr_ptr_in,
    input  wire [CHANNELS-1:0]       code_violation_in,
    input  wire [CHANNELS-1:0]       bipolar_violation_in,
    input  wire [CHANNELS-1:0]       excess_zeros_in,
    input  wire [CHANNELS-1:0]       counter_overflow_in,
    input  wire [CHANNELS-1:0]       all_ones_in,
    input  wire [CHANNELS-1:0]       signal_loss_in,
    input  wire [CHANNELS-1:0]       test_pattern_in,
    output wire                      irq_out
);
    wire        access;
    wire        wr_en;
    wire        rd_en;
    wire [9:0]  idx;
    wire [3:0]  ch_sel;
    wire [3:0]  reg_sel;
    wire        ch_region;
    reg  [7:0]  global_irq_reg;
    reg  [7:0]  global_cfg_reg;
    wire        global_irq_enable;
    wire        overflow_mode;
    wire [CHANNELS-1:0] ch_irq;

    // 32-bit word per register; index is the printed offset
    assign access    = psel_in && penable_in && clk_en_in;
    assign wr_en     = access && pwrite_in && pstrb_in[0];
    assign rd_en     = access && !pwrite_in;
    assign idx       = paddr_in[11:2];
    assign ch_sel    = idx[7:4];
    assign reg_sel   = idx[3:0];
    assign ch_region = (idx[9:8] == 2'b00) && (ch_sel < CHANNELS);
    assign pready_out  = 1'b1;
    assign pslverr_out = 1'b0;

    assign global_irq_enable = global_irq_reg[`BIT_GLOBAL_IRQ_EN];
    assign overflow_mode     = global_cfg_reg[`BIT_OVERFLOW_MODE];

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            global_irq_reg <= 8'h00;
            global_cfg_reg <= 8'h00;
        end else if (wr_en && idx == {2'b00, `IDX_GLOBAL_IRQ}) begin
            global_irq_reg <= pwdata_in[7:0];
        end else if (wr_en && idx == {2'b00, `IDX_GLOBAL_CFG}) begin
            global_cfg_reg <= pwdata_in[7:0];
        end
    end

    wire [CHANNELS*8-1:0] state_bus;
    wire [CHANNELS*8-1:0] change_bus;
    wire [CHANNELS*8-1:0] enable_bus;

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c = c + 1) begin : g_ch
            wire       near_limit;
            wire       violation_raw;
            wire [7:0] raw;
            wire [7:0] live;
            wire [7:0] changed;
            wire       sel;
            wire       rd_change;
            reg  [7:0] prev_reg;
            reg  [7:0] change_reg;
            reg  [7:0] enable_reg;

            fifo_near_limit_check #(
                .PTR_W (PTR_W)
            ) u_near (
                .rd_ptr_in      (fifo_rd_ptr_in[c*PTR_W +: PTR_W]),
                .wr_ptr_in      (fifo_wr_ptr_in[c*PTR_W +: PTR_W]),
                .near_limit_out (near_limit)
            );

            // Overflow mode swaps the violation source
            assign violation_raw = overflow_mode ? counter_overflow_in[c] :
                (code_violation_in[c] | bipolar_violation_in[c] | excess_zeros_in[c]);

            assign raw[7] = 1'b0;
            assign raw[6] = driver_fail_in[c];
            assign raw[5] = near_limit;
            assign raw[4] = violation_raw;
            assign raw[3] = 1'b0;
            assign raw[2] = all_ones_in[c];
            assign raw[1] = signal_loss_in[c];
            assign raw[0] = test_pattern_in[c];

            alarm_condition_sync #(
                .W (8)
            ) u_sync (
                .sys_clk_in (sys_clk_in),
                .rst_n_in   (rst_n_in),
                .clk_en_in  (clk_en_in),
                .level_in   (raw),
                .level_out  (live)
            );

            assign sel       = ch_region && (ch_sel == c);
            assign rd_change = rd_en && sel && ({4'h0, reg_sel} == `IDX_CH_ALARM_CHANGE);
            assign changed   = (live ^ prev_reg) & `ALARM_USED_MASK;

            always @(posedge sys_clk_in) begin
                if (!rst_n_in) begin
                    prev_reg   <= `ALARM_RESET;
                    change_reg <= 8'h00;
                    enable_reg <= 8'h00;
                end else if (clk_en_in) begin
                    prev_reg <= live;
                    // Clear only the flags that the read returned; new changes win
                    if (rd_change)
                        change_reg <= (change_reg & ~prdata_out[7:0]) | changed;
                    else
                        change_reg <= change_reg | changed;
                    if (wr_en && sel && {4'h0, reg_sel} == `IDX_CH_IRQ_EN)
                        enable_reg <= pwdata_in[7:0] & `ALARM_USED_MASK;
                end
            end

            // Status keeps tracking whatever the enables are
            assign state_bus[c*8 +: 8]  = live & `ALARM_USED_MASK;
            assign change_bus[c*8 +: 8] = change_reg;
            assign enable_bus[c*8 +: 8] = enable_reg;
            assign ch_irq[c] = |(change_reg & enable_reg);
        end
    endgenerate

    assign irq_out = global_irq_enable && (|ch_irq);

    // Read data registered; status register is read-only
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        if (ch_region) begin
            case ({4'h0, reg_sel})
                `IDX_CH_IRQ_EN:       rd_byte = enable_bus[ch_sel*8 +: 8];
                `IDX_CH_ALARM_STATE:  rd_byte = state_bus[ch_sel*8 +: 8];
                `IDX_CH_ALARM_CHANGE: rd_byte = change_bus[ch_sel*8 +: 8];
                default:              rd_byte = 8'h00;
            endcase
        end else if (idx == {2'b00, `IDX_GLOBAL_IRQ}) begin
            rd_byte = global_irq_reg;
        end else if (idx == {2'b00, `IDX_GLOBAL_CFG}) begin
            rd_byte = global_cfg_reg;
        end
    end

    always @(posedge sys_clk_in) begin
        if (!rst_n_in)
            prdata_out <= 32'h00000000;
        else if (clk_en_in && psel_in && !penable_in && !pwrite_in)
            prdata_out <= {24'h000000, rd_byte};
    end
endmodule

// ==== tb/channel_alarm_monitor.sv ====
// Assertion checker for the channel alarm status block
`timescale 1ns/1ps
module channel_alarm_monitor #(
    parameter CHANNELS = 8
) (
    input wire logic                sys_clk_in,
    input wire logic                rst_n_in,
    input wire logic                clk_en_in,
    input wire logic                psel_in,
    input wire logic                penable_in,
    input wire logic                pwrite_in,
    input wire logic [11:0]         paddr_in,
    input wire logic [31:0]         prdata_out,
    input wire logic                pready_out,
    input wire logic                pslverr_out,
    input wire logic [CHANNELS-1:0] driver_fail_in,
    input wire logic [CHANNELS-1:0] all_ones_in,
    input wire logic [CHANNELS-1:0] signal_loss_in,
    input wire logic [CHANNELS-1:0] test_pattern_in,
    input wire logic                irq_out
);
    logic [4*CHANNELS-1:0] p1_reg;
    logic [4*CHANNELS-1:0] p2_reg;
    wire       rd = psel_in && !penable_in && !pwrite_in && clk_en_in;
    wire [9:0] ix = paddr_in[11:2];
    wire [2:0] ch = paddr_in[8:6];
    wire       st = rd && ix < 10'h80 && ix[3:0] == 4'h5;
    // Input history matching the two-stage synchroniser
    always_ff @(posedge sys_clk_in) begin
        p1_reg <= {driver_fail_in, all_ones_in, signal_loss_in, test_pattern_in};
        p2_reg <= p1_reg;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_ready_fixed: assert property (pready_out && !pslverr_out) else $error("ready or error level wrong");
    chk_upper_zero: assert property (prdata_out[31:8] == 24'h0) else $error("upper read bits set");
    chk_unused_bits: assert property (rd && ix < 10'h80 |=> !prdata_out[7] && !prdata_out[3])
        else $error("unused bit reads one");
    chk_unmapped_zero: assert property (rd && ix > 10'h81 |=> prdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!rd |=> $stable(prdata_out)) else $error("read data moved");
    chk_tx_fail_bit: assert property (st |=> prdata_out[6] == $past(p2_reg[3*CHANNELS+ch]))
        else $error("driver fail bit wrong");
    chk_rx_alarm_bits: assert property (st |=> prdata_out[2:0] ==
        $past({p2_reg[2*CHANNELS+ch], p2_reg[CHANNELS+ch], p2_reg[ch]}))
        else $error("receive alarm bits wrong");
    chk_irq_reset: assert property ($rose(rst_n_in) |-> !irq_out) else $error("irq high after reset");
    cover property (st);
    cover property ($rose(irq_out));
    cover property (rd && ix > 10'h81);
endmodule
bind channel_alarm_status channel_alarm_monitor #(.CHANNELS(CHANNELS)) i_channel_alarm_monitor (.sys_clk_in,
    .rst_n_in, .clk_en_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out,
    .driver_fail_in, .all_ones_in, .signal_loss_in, .test_pattern_in, .irq_out);

// ==== tb/channel_alarm_status_tb.sv ====
// Self-checking bench for the channel alarm status block
`timescale 1ns/1ps
module channel_alarm_status_tb;
    logic        sys_clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic        pready_out, pslverr_out, irq_out, mode = 0;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, rd_val;
    logic [7:0]  df = 0, cv = 0, bv = 0, ez = 0, ov = 0, ao = 0, los = 0, tp = 0;
    logic [47:0] rp = 0, wp = {8{6'h20}}, nwp, nrp;
    logic [5:0]  dtab [4] = '{6'h3, 6'h4, 6'h3d, 6'h3c};
    int          bad_count = 0, checks_done = 0, cyc = 0;
    always #2 sys_clk_in = ~sys_clk_in;
    channel_alarm_status i_channel_alarm_status (.sys_clk_in, .rst_n_in, .clk_en_in(1'h1), .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in(4'hf), .pready_out, .prdata_out, .pslverr_out,
        .driver_fail_in(df), .fifo_rd_ptr_in(rp), .fifo_wr_ptr_in(wp), .code_violation_in(cv),
        .bipolar_violation_in(bv), .excess_zeros_in(ez), .counter_overflow_in(ov), .all_ones_in(ao),
        .signal_loss_in(los), .test_pattern_in(tp), .irq_out);
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [9:0] ix, input logic [7:0] d);
        @(posedge sys_clk_in);
        psel_in <= 1'h1;
        pwrite_in <= wr;
        paddr_in <= {ix, 2'h0};
        pwdata_in <= {24'h0, d};
        @(posedge sys_clk_in);
        penable_in <= 1'h1;
        do @(posedge sys_clk_in); while (pready_out !== 1'h1);
        rd_val = prdata_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask
    function automatic logic [7:0] exp_st(int c);
        logic [5:0] d;
        d = wp[c*6+:6] - rp[c*6+:6];
        return {1'h0, df[c], d <= 6'h3 || d >= 6'h3d, mode ? ov[c] : cv[c] | bv[c] | ez[c], 1'h0, ao[c], los[c], tp[c]};
    endfunction
    task automatic flip_loss;
        @(posedge sys_clk_in);
        los[2] <= ~los[2];
        repeat (4) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask
    initial begin
        void'($urandom(32'h8c5e1db6));
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1'h1;
        for (int k = 0; k < 32; k++) begin
            apb(1'h0, 10'h4 + 10'(16 * (k % 8) + k / 8), 8'h0);
            chk("reset value", rd_val, 32'h0);
        end
        $display("reset test done");
        for (int i = 0; i < 24; i++) begin
            mode = i[0];
            apb(1'h1, 10'h81, {mode, 7'h0});
            if (i % 3 == 0) apb(1'h1, 10'h5 + 10'(16 * (i % 8)), 8'hff);
            @(posedge sys_clk_in);
            {df, cv, bv, ez, ov, ao, los, tp} <= {$urandom, $urandom};
            nrp = {$urandom, $urandom};
            for (int c = 0; c < 8; c++) nwp[c*6+:6] = nrp[c*6+:6] + (i < 4 ? dtab[(i + c) % 4] : 6'($urandom));
            rp <= nrp;
            wp <= nwp;
            repeat (2) @(posedge sys_clk_in);
            apb(1'h0, 10'h5 + 10'(16 * (i % 8)), 8'h0);
            chk("status", rd_val, {24'h0, exp_st(i % 8)});
        end
        apb(1'h0, 10'h90, 8'h0);
        chk("unmapped", rd_val, 32'h0);
        $display("status test done");
        apb(1'h1, 10'h80, 8'h0);
        apb(1'h1, 10'h24, 8'hff);
        apb(1'h0, 10'h24, 8'h0);
        chk("enable", rd_val, 32'h77);
        apb(1'h0, 10'h26, 8'h0);
        flip_loss();
        chk("irq global off", irq_out, 32'h0);
        apb(1'h0, 10'h25, 8'h0);
        chk("status", rd_val, {24'h0, exp_st(2)});
        apb(1'h1, 10'h80, 8'h1);
        @(negedge sys_clk_in);
        chk("irq on", irq_out, 32'h1);
        apb(1'h0, 10'h26, 8'h0);
        chk("change", rd_val, 32'h2);
        @(negedge sys_clk_in);
        chk("irq cleared", irq_out, 32'h0);
        apb(1'h1, 10'h24, 8'hfd);
        flip_loss();
        chk("irq masked", irq_out, 32'h0);
        apb(1'h1, 10'h24, 8'h02);
        @(negedge sys_clk_in);
        chk("irq unmasked", irq_out, 32'h1);
        $display("irq test done");
        report_and_stop();
    end
endmodule
